/* File: src/lca_pkg.sv */
// constants, opcodes and register map of the logic and compare unit
package lca_pkg;
  localparam int DATA_W = 32;
  localparam int HALF_W = 16;
  localparam int STK_DEPTH = 8;
  localparam int STK_AW = 3;
  localparam int SP_W = 4;
  localparam int BS_START_W = 5;
  localparam int BS_COUNT_W = 6;
  localparam int DISC_W = 64;
  localparam int IRQ_W = 3;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_OPERAND = 8'h04;
  localparam logic [7:0] REG_BIT_SEL = 8'h08;
  localparam logic [7:0] REG_DISC_LO = 8'h0C;
  localparam logic [7:0] REG_DISC_HI = 8'h10;
  localparam logic [7:0] REG_ACC = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_STACK_TOP = 8'h1C;
  localparam logic [7:0] REG_IRQ_STAT = 8'h20;
  localparam logic [7:0] REG_IRQ_CLR = 8'h24;
  localparam logic [7:0] REG_IRQ_EN = 8'h28;

  // field positions
  localparam int CTRL_OP_LSB = 0;
  localparam int BS_START_LSB = 0;
  localparam int BS_COUNT_LSB = 8;
  localparam int ST_LESS = 0;
  localparam int ST_EQUAL = 1;
  localparam int ST_GREATER = 2;
  localparam int ST_ZERO = 3;
  localparam int ST_NEG = 4;
  localparam int ST_BUSY = 5;
  localparam int ST_DEPTH_LSB = 8;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_UNDERFLOW = 1;
  localparam int IRQ_OVERFLOW = 2;

  // reset value, zero half word, stack pointer step and full level
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [15:0] ZERO_HALF = 16'h0000;
  localparam logic [SP_W-1:0] SP_ONE = 4'h1;
  localparam logic [SP_W-1:0] SP_FULL = 4'h8;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_EXCLUSIVE_OR_WORD = 4'h1,
    OP_EXCLUSIVE_OR_DOUBLE = 4'h2,
    OP_EXCLUSIVE_OR_BIT_RANGE = 4'h3,
    OP_EXCLUSIVE_OR_STACK = 4'h4,
    OP_COMPARE_WORD = 4'h5,
    OP_COMPARE_DOUBLE = 4'h6,
    OP_COMPARE_BIT_RANGE = 4'h7,
    OP_COMPARE_STACK = 4'h8,
    OP_PUSH = 4'h9
  } lca_op_type;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_FETCH = 2'b01,
    S_EXEC = 2'b10
  } lca_state_type;
endpackage : lca_pkg

/* File: src/lca_stack_mem.sv */
// accumulator stack storage with registered read port
`timescale 1ns/1ps
module lca_stack_mem
  import lca_pkg::*;
(
  // clock
  input wire logic clk_i,
  // write port
  input wire logic we_i,
  input wire logic [STK_AW-1:0] waddr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  // read port
  input wire logic [STK_AW-1:0] raddr_i,
  output logic [DATA_W-1:0] rdata_o
);
  logic [DATA_W-1:0] mem_q [STK_DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_q[raddr_i];
  end
endmodule : lca_stack_mem

/* File: src/lca_bit_pack.sv */
// packs a run of discrete bits into an accumulator-aligned word
`timescale 1ns/1ps
module lca_bit_pack
  import lca_pkg::*;
(
  // bit image and selection
  input wire logic [DISC_W-1:0] image_i,
  input wire logic [BS_START_W-1:0] start_i,
  input wire logic [BS_COUNT_W-1:0] count_i,
  // packed result
  output logic [DATA_W-1:0] packed_o
);
  genvar i;
  generate
    for (i = 0; i < DATA_W; i++) begin : g_bit
      // start bit lands in bit 0, bits past the count read zero [RULE17]
      wire [BS_START_W:0] src_w = {1'b0, start_i} + (BS_START_W+1)'(i);
      assign packed_o[i] = (BS_COUNT_W'(i) < count_i) ? image_i[src_w] : 1'b0;
    end
  endgenerate
endmodule : lca_bit_pack

/* File: src/lca_core.sv */
// logic and compare unit with wishbone register slave
// Operation
// (RULE1) word xor: low 16 accumulator bits xor memory word, result in acc
// (RULE2) word xor sets zero flag when the result is zero
// (RULE3) double xor: 32-bit acc xor double word or constant into acc
// (RULE4) double xor updates zero flag and negative flag from bit 31
// (RULE5) bit-range xor: acc xor 1 to 32 bits from start and count
// (RULE6) bit-range xor updates zero and negative flags
// (RULE7) stack xor: acc xor top stack entry, result in acc
// (RULE8) consuming the stack top pops it, remaining entries move up
// (RULE9) stack xor updates zero and negative flags
// (RULE10) a flag holds until the next operation writing that flag
// (RULE11) word compare: low 16 acc bits against memory word
// (RULE12) compare result on less, equal and greater flags
// (RULE13) double compare: 32-bit acc against double word or constant
// (RULE14) bit-range compare: acc against 1 to 32 packed bits
// (RULE15) stack compare: 32-bit acc against top stack entry
// (RULE16) compares change only relation flags, never the accumulator
// (RULE17) packed bits start at acc bit 0, unused upper bits cleared
// (RULE18) exactly one relation flag set after a compare
//
// Implementation choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
module lca_core
  import lca_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [DATA_W-1:0] wb_dat_i,
  output logic [DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // interrupt
  output logic irq_o,
  // status flags
  output logic less_than_flag_o,
  output logic equal_flag_o,
  output logic greater_than_flag_o,
  output logic zero_result_flag_o,
  output logic negative_result_flag_o
);
  function automatic logic [DATA_W-1:0] lca_merge(
    input logic [DATA_W-1:0] old_v,
    input logic [DATA_W-1:0] new_v,
    input logic [3:0] sel
  );
    logic [DATA_W-1:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : lca_merge

  lca_state_type state_q, state_d;
  lca_op_type op_q;
  logic [DATA_W-1:0] operand_q, acc_q, acc_d;
  logic [DATA_W-1:0] bit_sel_q, disc_lo_q, disc_hi_q;
  logic [SP_W-1:0] sp_q, sp_d;
  logic [IRQ_W-1:0] irq_stat_q, irq_en_q;
  logic [DATA_W-1:0] stk_rdata;
  logic [DATA_W-1:0] packed_bits;

  // bus decode
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr = bus_req & wb_we_i;
  wire idle = (state_q == S_IDLE);
  wire wr_ctrl = bus_wr & (wb_adr_i == REG_CTRL);
  wire wr_operand = bus_wr & (wb_adr_i == REG_OPERAND);
  wire wr_bit_sel = bus_wr & (wb_adr_i == REG_BIT_SEL);
  wire wr_disc_lo = bus_wr & (wb_adr_i == REG_DISC_LO);
  wire wr_disc_hi = bus_wr & (wb_adr_i == REG_DISC_HI);
  // the accumulator is only writable while no operation is in flight
  wire wr_acc = bus_wr & idle & (wb_adr_i == REG_ACC);
  wire wr_irq_clr = bus_wr & (wb_adr_i == REG_IRQ_CLR) & wb_sel_i[0];
  wire wr_irq_en = bus_wr & (wb_adr_i == REG_IRQ_EN) & wb_sel_i[0];
  wire start = wr_ctrl & idle & wb_sel_i[0];
  wire exec = (state_q == S_EXEC);

  // operation class decode
  wire is_word = (op_q == OP_EXCLUSIVE_OR_WORD) | (op_q == OP_COMPARE_WORD);
  wire is_bits = (op_q == OP_EXCLUSIVE_OR_BIT_RANGE) |
                 (op_q == OP_COMPARE_BIT_RANGE);
  wire is_stack = (op_q == OP_EXCLUSIVE_OR_STACK) |
                  (op_q == OP_COMPARE_STACK);
  wire is_xor = (op_q == OP_EXCLUSIVE_OR_WORD) |
                (op_q == OP_EXCLUSIVE_OR_DOUBLE) |
                (op_q == OP_EXCLUSIVE_OR_BIT_RANGE) |
                (op_q == OP_EXCLUSIVE_OR_STACK);
  wire is_compare = (op_q == OP_COMPARE_WORD) |
                    (op_q == OP_COMPARE_DOUBLE) |
                    (op_q == OP_COMPARE_BIT_RANGE) |
                    (op_q == OP_COMPARE_STACK);
  wire is_push = (op_q == OP_PUSH);
  // only the xor form consumes the top; a compare leaves the stack [RULE16]
  wire is_xor_stack = (op_q == OP_EXCLUSIVE_OR_STACK);
  wire underflow = is_stack & (sp_q == '0);
  wire overflow = is_push & (sp_q == SP_FULL);
  wire fault = underflow | overflow;
  wire do_xor = exec & is_xor & ~fault;
  wire do_compare = exec & is_compare & ~fault;

  // operand selection; word forms use only the low half [RULE1] [RULE11]
  wire [DATA_W-1:0] lhs = is_word ? {ZERO_HALF, acc_q[HALF_W-1:0]} : acc_q;
  wire [DATA_W-1:0] rhs_mem = is_word ?
                              {ZERO_HALF, operand_q[HALF_W-1:0]} : operand_q;
  // stack top feeds xor and compare [RULE7] [RULE15]
  wire [DATA_W-1:0] rhs = is_stack ? stk_rdata :
                          is_bits ? packed_bits : rhs_mem;
  // one result path for all four xor forms [RULE3] [RULE5]
  wire [DATA_W-1:0] xor_res = lhs ^ rhs;
  wire res_zero = (xor_res == RST_WORD);
  wire rel_less = (lhs < rhs);
  wire rel_equal = (lhs == rhs);
  wire rel_greater = (lhs > rhs);

  wire [DATA_W-1:0] status_w = {
    {(DATA_W-ST_DEPTH_LSB-SP_W){1'b0}}, sp_q, 2'b00, ~idle,
    negative_result_flag_o, zero_result_flag_o,
    greater_than_flag_o, equal_flag_o, less_than_flag_o};
  wire [IRQ_W-1:0] irq_event = {exec & overflow, exec & underflow, exec};
  wire [DATA_W-1:0] rd_mux =
    (wb_adr_i == REG_CTRL) ? {28'h0000000, op_q} :
    (wb_adr_i == REG_OPERAND) ? operand_q :
    (wb_adr_i == REG_BIT_SEL) ? bit_sel_q :
    (wb_adr_i == REG_DISC_LO) ? disc_lo_q :
    (wb_adr_i == REG_DISC_HI) ? disc_hi_q :
    (wb_adr_i == REG_ACC) ? acc_q :
    (wb_adr_i == REG_STATUS) ? status_w :
    (wb_adr_i == REG_STACK_TOP) ? stk_rdata :
    (wb_adr_i == REG_IRQ_STAT) ? {29'h00000000, irq_stat_q} :
    (wb_adr_i == REG_IRQ_EN) ? {29'h00000000, irq_en_q} : RST_WORD;

  lca_bit_pack u_pack (
    .image_i({disc_hi_q, disc_lo_q}),
    .start_i(bit_sel_q[BS_START_LSB +: BS_START_W]),
    .count_i(bit_sel_q[BS_COUNT_LSB +: BS_COUNT_W]),
    .packed_o(packed_bits)
  ); // [RULE5] [RULE14] [RULE17]

  // top entry sits below the pointer, so a pop is a pointer step [RULE8]
  wire [STK_AW-1:0] stk_raddr = STK_AW'(sp_q - SP_ONE);
  lca_stack_mem u_stack (
    .clk_i(clk_i),
    .we_i(exec & is_push & ~overflow),
    .waddr_i(sp_q[STK_AW-1:0]),
    .wdata_i(acc_q),
    .raddr_i(stk_raddr),
    .rdata_o(stk_rdata)
  );

  // sequencer: fetch gives the registered stack read a cycle to settle
  always_comb begin
    case (state_q)
      S_IDLE: state_d = start ? S_FETCH : S_IDLE;
      S_FETCH: state_d = S_EXEC;
      S_EXEC: state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
  end

  // only an xor writes the result path; compares never do [RULE16]
  always_comb begin
    acc_d = acc_q;
    if (do_xor) begin
      acc_d = xor_res; // [RULE1] [RULE3] [RULE7]
    end else if (wr_acc) begin
      acc_d = lca_merge(acc_q, wb_dat_i, wb_sel_i);
    end
  end

  always_comb begin
    sp_d = sp_q;
    if (exec & is_xor_stack & ~underflow) begin
      sp_d = sp_q - SP_ONE; // [RULE8]
    end else if (exec & is_push & ~overflow) begin
      sp_d = sp_q + SP_ONE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= S_IDLE;
      op_q <= OP_NOP;
      acc_q <= RST_WORD;
      sp_q <= '0;
    end else begin
      state_q <= state_d;
      acc_q <= acc_d;
      sp_q <= sp_d;
      if (start) begin
        op_q <= lca_op_type'(wb_dat_i[CTRL_OP_LSB +: 4]);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      operand_q <= RST_WORD;
      bit_sel_q <= RST_WORD;
      disc_lo_q <= RST_WORD;
      disc_hi_q <= RST_WORD;
    end else begin
      if (wr_operand) operand_q <= lca_merge(operand_q, wb_dat_i, wb_sel_i);
      if (wr_bit_sel) bit_sel_q <= lca_merge(bit_sel_q, wb_dat_i, wb_sel_i);
      if (wr_disc_lo) disc_lo_q <= lca_merge(disc_lo_q, wb_dat_i, wb_sel_i);
      if (wr_disc_hi) disc_hi_q <= lca_merge(disc_hi_q, wb_dat_i, wb_sel_i);
    end
  end

  // each flag is rewritten only by an operation that owns it [RULE10]
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      less_than_flag_o <= 1'b0;
      equal_flag_o <= 1'b0;
      greater_than_flag_o <= 1'b0;
      zero_result_flag_o <= 1'b0;
      negative_result_flag_o <= 1'b0;
    end else begin
      if (do_compare) begin
        less_than_flag_o <= rel_less; // [RULE12] [RULE18]
        equal_flag_o <= rel_equal; // [RULE13] [RULE14] [RULE15]
        greater_than_flag_o <= rel_greater;
      end
      if (do_xor) begin
        zero_result_flag_o <= res_zero; // [RULE2] [RULE4] [RULE6] [RULE9]
      end
      // word xor reports zero only; wider forms also report sign
      if (do_xor & ~is_word) begin
        negative_result_flag_o <= xor_res[DATA_W-1]; // [RULE4] [RULE6]
      end
    end
  end

  // interrupt: set wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= '0;
      irq_en_q <= '0;
      irq_o <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~(wr_irq_clr ? wb_dat_i[IRQ_W-1:0] : '0))
                    | irq_event;
      if (wr_irq_en) irq_en_q <= wb_dat_i[IRQ_W-1:0];
      irq_o <= |(irq_stat_q & irq_en_q);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= RST_WORD;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req & ~wb_we_i) wb_dat_o <= rd_mux;
    end
  end

  // checks; shadow registers hold the operands of the executing cycle
  logic [DATA_W-1:0] chk_acc_q, chk_opd_q, chk_top_q;
  always_ff @(posedge clk_i) begin
    chk_acc_q <= acc_q;
    chk_opd_q <= operand_q;
    chk_top_q <= stk_rdata;
  end

  a_compare_keeps_acc: assert property ( // [RULE16]
    @(posedge clk_i) disable iff (rst_i)
    exec & is_compare |=> acc_q == chk_acc_q)
    else $error("compare changed the accumulator");
  a_compare_keeps_stack: assert property ( // [RULE16]
    @(posedge clk_i) disable iff (rst_i)
    exec & (op_q == OP_COMPARE_STACK) |=> $stable(sp_q))
    else $error("stack compare moved the stack pointer");
  a_relation_onehot: assert property ( // [RULE18]
    @(posedge clk_i) disable iff (rst_i)
    do_compare |=> $onehot({less_than_flag_o, equal_flag_o,
                            greater_than_flag_o}))
    else $error("relation flags not one-hot after compare");
  a_word_xor_res: assert property ( // [RULE1]
    @(posedge clk_i) disable iff (rst_i)
    exec & (op_q == OP_EXCLUSIVE_OR_WORD) |=>
    acc_q == {ZERO_HALF, chk_acc_q[HALF_W-1:0] ^ chk_opd_q[HALF_W-1:0]})
    else $error("word xor result wrong");
  a_word_neg_kept: assert property ( // [RULE10]
    @(posedge clk_i) disable iff (rst_i)
    exec & (op_q == OP_EXCLUSIVE_OR_WORD) |=>
    $stable(negative_result_flag_o))
    else $error("word xor changed the negative flag");
  a_double_xor_res: assert property ( // [RULE3]
    @(posedge clk_i) disable iff (rst_i)
    exec & (op_q == OP_EXCLUSIVE_OR_DOUBLE) |=>
    acc_q == (chk_acc_q ^ chk_opd_q))
    else $error("double xor result wrong");
  a_stack_xor_res: assert property ( // [RULE7]
    @(posedge clk_i) disable iff (rst_i)
    exec & is_xor_stack & ~underflow |=> acc_q == (chk_acc_q ^ chk_top_q))
    else $error("stack xor result wrong");
  a_zero_flag_set: assert property ( // [RULE2]
    @(posedge clk_i) disable iff (rst_i)
    do_xor |=> zero_result_flag_o == (acc_q == RST_WORD))
    else $error("zero flag disagrees with accumulator");
  a_neg_flag_set: assert property ( // [RULE4]
    @(posedge clk_i) disable iff (rst_i)
    do_xor & ~is_word |=> negative_result_flag_o == acc_q[DATA_W-1])
    else $error("negative flag disagrees with accumulator");
  a_stack_pop_step: assert property ( // [RULE8]
    @(posedge clk_i) disable iff (rst_i)
    exec & is_xor_stack & ~underflow |=> sp_q == $past(sp_q) - SP_ONE)
    else $error("stack not popped");
  a_underflow_keeps: assert property ( // [RULE8]
    @(posedge clk_i) disable iff (rst_i)
    exec & underflow |=> $stable(acc_q) && $stable(sp_q))
    else $error("empty stack operation changed state");
  a_flags_hold_xor: assert property ( // [RULE10]
    @(posedge clk_i) disable iff (rst_i)
    exec & ~is_compare |=> $stable({less_than_flag_o, equal_flag_o,
                                    greater_than_flag_o}))
    else $error("relation flag changed by non-compare");
  a_word_compare_less: assert property ( // [RULE11]
    @(posedge clk_i) disable iff (rst_i)
    exec & (op_q == OP_COMPARE_WORD) |=>
    less_than_flag_o == (chk_acc_q[HALF_W-1:0] < chk_opd_q[HALF_W-1:0]))
    else $error("word compare less flag wrong");
  a_double_compare_gt: assert property ( // [RULE13]
    @(posedge clk_i) disable iff (rst_i)
    exec & (op_q == OP_COMPARE_DOUBLE) |=>
    greater_than_flag_o == (chk_acc_q > chk_opd_q))
    else $error("double compare greater flag wrong");
  a_done_sets: assert property (
    @(posedge clk_i) disable iff (rst_i)
    exec |=> irq_stat_q[IRQ_DONE])
    else $error("done status not set after an operation");
  a_irq_follows: assert property (
    @(posedge clk_i) disable iff (rst_i)
    |(irq_stat_q & irq_en_q) |=> irq_o)
    else $error("enabled status bit did not raise the interrupt");
  a_start_to_exec: assert property (
    @(posedge clk_i) disable iff (rst_i)
    start |-> ##2 exec ##1 idle)
    else $error("operation did not execute two cycles after start");
endmodule : lca_core

/* File: testbench/lca_core_test.sv */
// self-checking bench of the logic and compare unit over wishbone
`timescale 1ns/1ps
module lca_core_test;
  import lca_pkg::*;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, irq;
  logic lt_o, eq_o, gt_o, z_o, n_o;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int errors, samples_checked, dep, k, i;
  logic [31:0] acc, opd, pk, smask;
  logic [31:0] stk[8];
  logic [63:0] img;
  logic [4:0] flg;
  logic [2:0] ist;
  logic [4:0] bs_st;
  logic [5:0] bs_ct;

  lca_core i_lca_core (
    .clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack), .irq_o(irq),
    .less_than_flag_o(lt_o), .equal_flag_o(eq_o),
    .greater_than_flag_o(gt_o), .zero_result_flag_o(z_o),
    .negative_result_flag_o(n_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic final_report();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one classic cycle; request held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat_i <= d;
    wb_sel <= s;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    bus(1'b0, a, 32'h0000_0000, 4'hF);
  endtask : rd

  // read data checked against the oldest note when it appears
  always @(posedge clk_i) begin
    if (wb_ack === 1'b1 && wb_we === 1'b0 && exp_q.size() > 0) begin
      chk(wb_dat_o & msk_q.pop_front(), exp_q.pop_front());
    end
  end

  task automatic zn();
    flg[3] = (acc == 32'h0000_0000);
    flg[4] = acc[31];
  endtask : zn

  task automatic rel(input logic [31:0] a, input logic [31:0] b);
    flg[2:0] = {a > b, a == b, a < b};
  endtask : rel

  task automatic model(input logic [3:0] c);
    ist[IRQ_DONE] = 1'b1;
    pk = 32'h0000_0000;
    for (k = 0; k < 32; k++) if (k < bs_ct) pk[k] = img[bs_st + k];
    case (c)
      4'h1: begin
        acc = {16'h0000, acc[15:0] ^ opd[15:0]};
        flg[3] = (acc == 32'h0000_0000);
      end
      4'h2: begin acc = acc ^ opd; zn(); end
      4'h3: begin acc = acc ^ pk; zn(); end
      4'h4: begin
        if (dep == 0) ist[IRQ_UNDERFLOW] = 1'b1;
        else begin dep--; acc = acc ^ stk[dep]; zn(); end
      end
      4'h5: rel({16'h0000, acc[15:0]}, {16'h0000, opd[15:0]});
      4'h6: rel(acc, opd);
      4'h7: rel(acc, pk);
      4'h8: begin
        if (dep == 0) ist[IRQ_UNDERFLOW] = 1'b1;
        else rel(acc, stk[dep - 1]);
      end
      4'h9: begin
        if (dep == 8) ist[IRQ_OVERFLOW] = 1'b1;
        else begin stk[dep] = acc; dep++; end
      end
      default: ;
    endcase
  endtask : model

  // three edges of work; four waited so irq has settled too
  task automatic op(input logic [3:0] c);
    model(c);
    wr(REG_CTRL, {28'h0000000, c});
    repeat (4) @(posedge clk_i);
    chk({27'h0, n_o, z_o, gt_o, eq_o, lt_o}, {27'h0, flg});
    rd(REG_STATUS, {20'h0, 4'(dep), 3'b000, flg}, smask);
    rd(REG_ACC, acc, 32'hFFFF_FFFF);
  endtask : op

  initial begin
    #(25 * 20000);
    errors++;
    final_report();
  end

  initial begin
    void'($urandom(32'hc8e4));
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_i} = '0;
    {errors, samples_checked, dep} = '0;
    {acc, opd, img, flg, ist, bs_st, bs_ct} = '0;
    smask = 32'hFFFF_FFFF;
    rst_i = 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(REG_STATUS, RST_WORD, smask);
    rd(REG_IRQ_STAT, RST_WORD, smask);
    rd(8'h30, RST_WORD, smask);
    wr(REG_IRQ_EN, 32'h0000_0000);
    op(OP_EXCLUSIVE_OR_STACK);
    chk({31'h0, irq}, 32'h0);
    rd(REG_IRQ_STAT, {29'h0, ist}, smask);
    wr(REG_IRQ_EN, 32'h0000_0007);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq}, 32'h1);
    wr(REG_IRQ_CLR, 32'h0000_0007);
    ist = 3'b000;
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq}, 32'h0);
    for (i = 0; i < 9; i++) begin
      acc = $urandom();
      wr(REG_ACC, acc);
      op(OP_PUSH);
    end
    rd(REG_STACK_TOP, stk[7], smask);
    rd(REG_IRQ_STAT, {29'h0, ist}, smask);
    wr(REG_IRQ_CLR, 32'h0000_0007);
    ist = 3'b000;
    wr(REG_OPERAND, 32'h0000_0000);
    bus(1'b1, REG_OPERAND, 32'hFFFF_FFFF, 4'h3);
    opd = 32'h0000_FFFF;
    op(OP_EXCLUSIVE_OR_DOUBLE);
    for (i = 0; i < 56; i++) begin
      opd = (i % 3 == 0) ? acc : $urandom();
      bs_st = 5'($urandom());
      bs_ct = 6'($urandom_range(40, 0));
      if (i == 6) bs_ct = 6'h00;
      if (i == 13) begin bs_st = 5'h1F; bs_ct = 6'h20; end
      img = {$urandom(), $urandom()};
      wr(REG_OPERAND, opd);
      wr(REG_BIT_SEL, {18'h0, bs_ct, 3'h0, bs_st});
      wr(REG_DISC_LO, img[31:0]);
      wr(REG_DISC_HI, img[63:32]);
      op(4'(1 + i % 7));
    end
    acc = $urandom();
    wr(REG_ACC, acc);
    op(OP_PUSH);
    acc = acc ^ 32'h0000_0100;
    wr(REG_ACC, acc);
    op(OP_COMPARE_STACK);
    op(OP_NOP);
    op(OP_EXCLUSIVE_OR_STACK);
    op(OP_COMPARE_STACK);
    rd(REG_IRQ_STAT, {29'h0, ist}, 32'hFFFF_FFFF);
    final_report();
  end
endmodule : lca_core_test
